/* File: hdl/sfps_pkg.sv */
package sfps_pkg;
  // =====================================================
  // Timing
  // =====================================================
  localparam int CLK_MHZ = 125;
  localparam int POWER_UP_WAIT_MS = 2;
  localparam int POWER_UP_WAIT_CYC = POWER_UP_WAIT_MS * 1000 * CLK_MHZ;
  localparam int SLEEP_ENTRY_DELAY_US = 3;
  localparam int SLEEP_ENTRY_DELAY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
  localparam int NORMAL_READ_MAX_MHZ = 33;
  localparam int OTHER_CMD_MAX_MHZ = 50;
  // Host clock divider half periods, rounded up so the ceiling is kept
  localparam int READ_HALF_CEIL_CYC =
    (CLK_MHZ + 2 * NORMAL_READ_MAX_MHZ - 1) / (2 * NORMAL_READ_MAX_MHZ);
  localparam int OTHER_HALF_CEIL_CYC =
    (CLK_MHZ + 2 * OTHER_CMD_MAX_MHZ - 1) / (2 * OTHER_CMD_MAX_MHZ);
  // Read data returns through both synchronisers, so a period must span six cycles
  localparam int LINK_HALF_MIN_CYC = 3;
  localparam int READ_HALF_CYC =
    (READ_HALF_CEIL_CYC > LINK_HALF_MIN_CYC) ? READ_HALF_CEIL_CYC : LINK_HALF_MIN_CYC;
  localparam int OTHER_HALF_CYC =
    (OTHER_HALF_CEIL_CYC > LINK_HALF_MIN_CYC) ? OTHER_HALF_CEIL_CYC : LINK_HALF_MIN_CYC;
  localparam int CS_HIGH_CYC = 13;
  // =====================================================
  // Instruction codes
  // =====================================================
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;
  localparam logic [7:0] WRITE_LOCK_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] SECTOR_CLEAR_CMD = 8'hD8;
  localparam logic [7:0] WHOLE_CLEAR_CMD = 8'hC7;
  localparam logic [7:0] SLEEP_CMD = 8'hB9;
  localparam logic [7:0] WAKE_CMD = 8'hAB;
  // =====================================================
  // Delivered contents
  // =====================================================
  localparam logic [7:0] MEM_ERASED = 8'hFF;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int WEL_BIT = 1;
  typedef enum logic [1:0] {
    SFPS_PWR_OFF = 2'b00,
    SFPS_PWR_WAIT = 2'b01,
    SFPS_PWR_STANDBY = 2'b10,
    SFPS_PWR_SLEEP = 2'b11
  } sfps_pwr_t;
endpackage

/* File: hdl/sfps_if.sv */
`timescale 1ns/1ns
interface sfps_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input sck, input cs_n, input si, output so, output so_oe);
  modport host (output sck, output cs_n, output si, input so, input so_oe);
endinterface // sfps_if

/* File: hdl/sfps_device.sv */
`timescale 1ns/1ns
module sfps_device
  import sfps_pkg::*;
#(
  parameter int PU_WAIT_CYC = POWER_UP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  sfps_if.dev spi,
  input wire logic supply_ok,
  output logic in_sleep,
  output logic ready,
  output logic write_enable_latch_bit,
  output logic [7:0] last_cmd
);

  // =====================================================
  // Pin synchronisers
  // =====================================================
  logic [1:0] sck_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] si_s_q;
  logic [1:0] ok_s_q;
  logic sck_old_q;
  // Two flops on every pin; only the second one is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      si_s_q <= 2'h0;
      ok_s_q <= 2'h0;
      sck_old_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], spi.sck};
      cs_s_q <= {cs_s_q[0], spi.cs_n};
      si_s_q <= {si_s_q[0], spi.si};
      ok_s_q <= {ok_s_q[0], supply_ok};
      sck_old_q <= sck_s_q[1];
    end
  end

  wire sck_v = sck_s_q[1];
  wire cs_n_v = cs_s_q[1];
  wire si_v = si_s_q[1];
  wire ok_v = ok_s_q[1];

  wire sck_rise = sck_v && !sck_old_q;
  wire sck_fall = !sck_v && sck_old_q;

  logic cs_old_q;
  wire cs_rise = cs_n_v && !cs_old_q;
  wire cs_fall = !cs_n_v && cs_old_q;

  // =====================================================
  // Power state
  // =====================================================
  sfps_pwr_t pwr_q, pwr_d;
  logic [31:0] pu_cnt_q;
  logic [31:0] dp_cnt_q;
  logic dp_pend_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] cmd_q;
  logic cmd_valid_q;
  logic [7:0] out_q;
  logic so_oe_q;
  logic [5:0] rd_bits_q;

  wire pu_done = (pu_cnt_q >= 32'(PU_WAIT_CYC));
  // Select synchroniser and edge detect use five cycles of the sleep entry budget
  wire dp_done = (dp_cnt_q >= 32'(SLEEP_ENTRY_DELAY_CYC - 5));

  // Decoder open only when powered, waited and selected
  wire dec_en = (pwr_q == SFPS_PWR_STANDBY || pwr_q == SFPS_PWR_SLEEP) && !cs_n_v;
  wire byte_done = dec_en && sck_rise && (bit_q == 4'd7);
  wire [7:0] byte_in = {sh_q[6:0], si_v};
  wire first_byte = !cmd_valid_q;

  // Sleep only honours wake
  wire cmd_ok = (pwr_q != SFPS_PWR_SLEEP) || (byte_in == WAKE_CMD);
  wire take_cmd = byte_done && first_byte && cmd_ok;
  wire end_frame = cs_rise && cmd_valid_q;

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      SFPS_PWR_OFF: if (ok_v) pwr_d = SFPS_PWR_WAIT;
      SFPS_PWR_WAIT: if (pu_done) pwr_d = SFPS_PWR_STANDBY;
      SFPS_PWR_STANDBY: if (dp_pend_q && dp_done) pwr_d = SFPS_PWR_SLEEP;
      SFPS_PWR_SLEEP: if (end_frame && cmd_q == WAKE_CMD) pwr_d = SFPS_PWR_STANDBY;
      default: pwr_d = SFPS_PWR_OFF;
    endcase
    if (!ok_v) pwr_d = SFPS_PWR_OFF;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q <= SFPS_PWR_OFF;
      pu_cnt_q <= 32'h0;
      cs_old_q <= 1'b1;
    end else begin
      pwr_q <= pwr_d;
      cs_old_q <= cs_n_v;
      if (pwr_q == SFPS_PWR_WAIT && !pu_done) pu_cnt_q <= pu_cnt_q + 32'h1;
      else if (pwr_q == SFPS_PWR_OFF) pu_cnt_q <= 32'h0;
    end
  end

  // Sleep entry timer, started by deselect after sleep_cmd
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dp_pend_q <= 1'b0;
      dp_cnt_q <= 32'h0;
    end else if (pwr_q != SFPS_PWR_STANDBY) begin
      dp_pend_q <= 1'b0;
      dp_cnt_q <= 32'h0;
    end else if (end_frame && cmd_q == SLEEP_CMD) begin
      dp_pend_q <= 1'b1;
      dp_cnt_q <= 32'h0;
    end else if (dp_pend_q) begin
      dp_cnt_q <= dp_cnt_q + 32'h1;
    end
  end

  // =====================================================
  // Shifter and command capture
  // =====================================================
  // Bits enter on the synchronised rising edge, MSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      cmd_q <= 8'h00;
      cmd_valid_q <= 1'b0;
    end else if (cs_n_v || !dec_en) begin
      bit_q <= 4'h0;
      cmd_valid_q <= 1'b0;
      if (cs_fall) cmd_q <= 8'h00;
    end else if (sck_rise) begin
      sh_q <= byte_in;
      bit_q <= (bit_q == 4'd7) ? 4'h0 : bit_q + 4'h1;
      if (take_cmd) begin
        cmd_q <= byte_in;
        cmd_valid_q <= 1'b1;
      end else if (byte_done && first_byte) begin
        cmd_q <= 8'h00;
        cmd_valid_q <= 1'b1;
      end
    end
  end

  // =====================================================
  // Latch and read data
  // =====================================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_enable_latch_bit <= 1'b0;
    end else if (pwr_q == SFPS_PWR_OFF || pwr_q == SFPS_PWR_WAIT) begin
      write_enable_latch_bit <= 1'b0;
    end else if (take_cmd && byte_in == WRITE_UNLOCK_CMD) begin
      write_enable_latch_bit <= 1'b1;
    end else if (take_cmd && byte_in == WRITE_LOCK_CMD) begin
      write_enable_latch_bit <= 1'b0;
    end
  end

  wire [7:0] status_v = STATUS_RESET | (8'(write_enable_latch_bit) << WEL_BIT);
  wire is_rd = cmd_q == READ_CMD;
  wire rd_start = cmd_valid_q && ((cmd_q == STATUS_READ_CMD) ||
                  (is_rd && rd_bits_q >= 6'd32) || (cmd_q == FAST_READ_CMD && rd_bits_q >= 6'd40));

  // Answer bits leave on the synchronised falling edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= 8'h00;
      so_oe_q <= 1'b0;
      rd_bits_q <= 6'h0;
    end else if (cs_n_v || !dec_en) begin
      so_oe_q <= 1'b0;
      rd_bits_q <= 6'h0;
    end else begin
      if (sck_rise && rd_bits_q != 6'h3F) rd_bits_q <= rd_bits_q + 6'h1;
      if (sck_fall && rd_start) begin
        so_oe_q <= 1'b1;
        if (bit_q == 4'h0) out_q <= (cmd_q == STATUS_READ_CMD) ? status_v : MEM_ERASED;
        else out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  assign spi.so = out_q[7];
  assign spi.so_oe = so_oe_q;
  assign in_sleep = (pwr_q == SFPS_PWR_SLEEP);
  assign ready = (pwr_q == SFPS_PWR_STANDBY);
  assign last_cmd = cmd_q;
endmodule // sfps_device

/* File: hdl/sfps_host.sv */
`timescale 1ns/1ns
module sfps_host
  import sfps_pkg::*;
#(
  parameter int PU_WAIT_CYC = POWER_UP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  sfps_if.host spi,
  input wire logic supply_ok,
  input wire logic req_valid,
  input wire logic [7:0] req_cmd,
  input wire logic [5:0] req_bytes,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid
);
  // =====================================================
  // Supply tracking
  // =====================================================
  logic [1:0] ok_s_q, so_s_q;
  logic [31:0] wait_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ok_s_q <= 2'h0;
      so_s_q <= 2'h0;
      wait_q <= 32'h0;
    end else begin
      ok_s_q <= {ok_s_q[0], supply_ok};
      so_s_q <= {so_s_q[0], spi.so};
      if (!ok_s_q[1]) wait_q <= 32'h0;
      else if (wait_q < 32'(PU_WAIT_CYC)) wait_q <= wait_q + 32'h1;
    end
  end
  // Select held off until supply up plus wait; covers writes too
  wire powered = ok_s_q[1] && (wait_q >= 32'(PU_WAIT_CYC));
  // =====================================================
  // Frame engine
  // =====================================================
  typedef enum logic [1:0] {
    SFPS_H_IDLE = 2'b00,
    SFPS_H_SHIFT = 2'b01,
    SFPS_H_GAP = 2'b10
  } sfps_hst_t;
  sfps_hst_t st_q;
  logic [7:0] tx_q, rx_q;
  logic [2:0] bit_q;
  logic [5:0] left_q;
  logic [3:0] div_q, half_q;
  logic sck_q, cs_n_q, first_q;
  wire tick = (div_q == 4'h0);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= SFPS_H_IDLE;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      left_q <= 6'h0;
      div_q <= 4'h0;
      half_q <= 4'h1;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      first_q <= 1'b0;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      div_q <= tick ? half_q - 4'h1 : div_q - 4'h1;
      case (st_q)
        SFPS_H_IDLE: begin
          cs_n_q <= 1'b1;
          if (req_valid && powered) begin
            st_q <= SFPS_H_SHIFT;
            cs_n_q <= 1'b0;
            tx_q <= req_cmd;
            left_q <= req_bytes;
            bit_q <= 3'h0;
            first_q <= 1'b1;
            // Normal read has its own half period; at 125 MHz both come to three cycles
            half_q <= (req_cmd == READ_CMD) ? 4'(READ_HALF_CYC) : 4'(OTHER_HALF_CYC);
            div_q <= 4'h0;
          end
        end
        SFPS_H_SHIFT: if (tick) begin
          if (!powered) begin
            st_q <= SFPS_H_GAP;
            sck_q <= 1'b0;
            left_q <= 6'(CS_HIGH_CYC);
          end else if (!sck_q) begin
            sck_q <= 1'b1;
          end else begin
            sck_q <= 1'b0;
            // Sample at the end of the bit cell: the answer needs five cycles to return
            rx_q <= {rx_q[6:0], so_s_q[1]};
            bit_q <= bit_q + 3'h1;
            tx_q <= {tx_q[6:0], 1'b0};
            if (bit_q == 3'h7) begin
              if (!first_q) begin
                rsp_data <= {rx_q[6:0], so_s_q[1]};
                rsp_valid <= 1'b1;
              end
              first_q <= 1'b0;
              tx_q <= 8'h00;
              if (left_q == 6'h0) begin
                st_q <= SFPS_H_GAP;
                left_q <= 6'(CS_HIGH_CYC);
              end else begin
                left_q <= left_q - 6'h1;
              end
            end
          end
        end
        // Select stays high for at least CS_HIGH_CYC + 1 cycles between frames
        SFPS_H_GAP: begin
          cs_n_q <= 1'b1;
          if (left_q == 6'h0) st_q <= SFPS_H_IDLE;
          else left_q <= left_q - 6'h1;
        end
        default: st_q <= SFPS_H_IDLE;
      endcase
    end
  end
  assign spi.sck = sck_q;
  assign spi.cs_n = cs_n_q || !powered;
  assign spi.si = tx_q[7];
  assign req_ready = (st_q == SFPS_H_IDLE) && powered;
endmodule // sfps_host

/* File: test/sfps_assertions.sv */
`timescale 1ns/1ns
module sfps_assertions
  import sfps_pkg::*;
#(
  parameter int PU_WAIT_CYC = POWER_UP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic supply_ok,
  input wire logic in_sleep,
  input wire logic ready,
  input wire logic write_enable_latch_bit,
  input wire logic [7:0] last_cmd
);
  localparam int SLEEP_MAX = SLEEP_ENTRY_DELAY_CYC;
  int up_q;
  int up_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==================================================
  // Cycles of good supply, saturating
  assign up_d = !supply_ok ? 0 : (up_q < PU_WAIT_CYC ? up_q + 1 : up_q);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up_q <= 0;
    else up_q <= up_d;
  end
  // ==================================================
  // Checks
  a_select_idle: assert property (!supply_ok [*5] |-> cs_n)
    else $error("select active without supply");
  a_ready_wait: assert property (ready |-> up_q >= PU_WAIT_CYC)
    else $error("ready before power-up wait");
  a_quiet_early: assert property (up_q > 4 && up_q < PU_WAIT_CYC |-> !write_enable_latch_bit)
    else $error("latch set during power-up wait");
  a_standby_up: assert property ($rose(ready) && !$past(in_sleep) |->
    !in_sleep && !write_enable_latch_bit)
    else $error("power-up not in standby with latch clear");
  a_supply_loss: assert property (!supply_ok [*5] |-> !ready && !in_sleep && !so_oe)
    else $error("device active without supply");
  a_sleep_entry: assert property ($rose(cs_n) ##[0:6] (ready && last_cmd == SLEEP_CMD) |->
    ##[0:SLEEP_MAX] (in_sleep || !supply_ok))
    else $error("sleep entry too late");
  a_sleep_refuses: assert property (in_sleep && $changed(last_cmd) |->
    last_cmd == 8'h00 || last_cmd == WAKE_CMD)
    else $error("opcode taken in sleep");
  a_unlock_latch: assert property ($changed(last_cmd) && last_cmd == WRITE_UNLOCK_CMD |->
    ##[0:8] write_enable_latch_bit)
    else $error("unlock did not set latch");
  a_sck_rate: assert property ($changed(sck) |=> $stable(sck))
    else $error("serial clock too fast");
endmodule // sfps_assertions

/* File: test/tb_serial_flash_power_sequencing.sv */
`timescale 1ns/1ns
module tb_serial_flash_power_sequencing
  import sfps_pkg::*;
;
  localparam int PU = 50;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic supply_ok = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] req_cmd = 8'h00;
  logic [5:0] req_bytes = 6'h00;
  logic req_ready;
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic in_sleep;
  logic ready;
  logic write_enable_latch_bit;
  logic [7:0] last_cmd;
  logic [7:0] rsp_last = 8'h00;
  int n_fail = 0;
  int checks = 0;
  sfps_if spi_if ();
  sfps_host #(.PU_WAIT_CYC(PU)) sfps_host_inst (.clk(clk), .reset_n(reset_n), .spi(spi_if),
    .supply_ok(supply_ok), .req_valid(req_valid), .req_cmd(req_cmd), .req_bytes(req_bytes),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  sfps_device #(.PU_WAIT_CYC(PU)) sfps_device_inst (.clk(clk), .reset_n(reset_n), .spi(spi_if),
    .supply_ok(supply_ok), .in_sleep(in_sleep), .ready(ready),
    .write_enable_latch_bit(write_enable_latch_bit), .last_cmd(last_cmd));
  sfps_assertions #(.PU_WAIT_CYC(PU)) sfps_assertions_inst (.clk(clk), .reset_n(reset_n),
    .sck(spi_if.sck), .cs_n(spi_if.cs_n), .so_oe(spi_if.so_oe), .supply_ok(supply_ok),
    .in_sleep(in_sleep), .ready(ready), .write_enable_latch_bit(write_enable_latch_bit),
    .last_cmd(last_cmd));
  // ==================================================
  // Helpers
  always @(posedge clk) if (rsp_valid) rsp_last <= rsp_data;
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] c, input logic [5:0] n);
    int i;
    req_cmd = c;
    req_bytes = n;
    req_valid = 1'b1;
    for (i = 0; i < 4000 && req_ready !== 1'b1; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 1'b0;
    repeat (2) @(posedge clk) #1;
    for (i = 0; i < 4000 && req_ready !== 1'b1; i++) @(posedge clk) #1;
    repeat (8) @(posedge clk) #1;
  endtask
  // ==================================================
  // Scenarios
  task automatic t_power_up();
    int i;
    supply_ok = 1'b1;
    repeat (PU) @(posedge clk) #1;
    chk("ready early", 8'(ready), 8'h00);
    chk("req_ready early", 8'(req_ready), 8'h00);
    for (i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk) #1;
    chk("ready", 8'(ready), 8'h01);
    chk("in_sleep", 8'(in_sleep), 8'h00);
    chk("latch", 8'(write_enable_latch_bit), 8'h00);
  endtask
  task automatic t_delivered();
    xfer(READ_CMD, 6'd4);
    chk("read data", rsp_last, MEM_ERASED);
    xfer(STATUS_READ_CMD, 6'd1);
    chk("status", rsp_last, STATUS_RESET);
    xfer(FAST_READ_CMD, 6'd5);
    chk("fast read", rsp_last, MEM_ERASED);
  endtask
  task automatic t_unlock();
    xfer(WRITE_UNLOCK_CMD, 6'd0);
    chk("latch", 8'(write_enable_latch_bit), 8'h01);
    xfer(STATUS_READ_CMD, 6'd1);
    chk("status", rsp_last, STATUS_RESET | 8'(1 << WEL_BIT));
  endtask
  task automatic t_commands();
    logic [7:0] c [9] = '{WRITE_UNLOCK_CMD, STATUS_WRITE_CMD, WRITE_UNLOCK_CMD, PAGE_WRITE_CMD,
      WRITE_UNLOCK_CMD, SECTOR_CLEAR_CMD, WRITE_UNLOCK_CMD, WHOLE_CLEAR_CMD, WRITE_LOCK_CMD};
    logic [5:0] n [9] = '{6'd0, 6'd1, 6'd0, 6'd4, 6'd0, 6'd3, 6'd0, 6'd0, 6'd0};
    for (int i = 0; i < 9; i++) begin
      xfer(c[i], n[i]);
      chk("opcode", last_cmd, c[i]);
    end
  endtask
  task automatic t_sleep();
    int i;
    xfer(WRITE_UNLOCK_CMD, 6'd0);
    xfer(SLEEP_CMD, 6'd0);
    for (i = 0; i < SLEEP_ENTRY_DELAY_CYC && in_sleep !== 1'b1; i++) @(posedge clk) #1;
    chk("in_sleep", 8'(in_sleep), 8'h01);
    xfer(STATUS_READ_CMD, 6'd1);
    chk("opcode", last_cmd, 8'h00);
    chk("in_sleep", 8'(in_sleep), 8'h01);
    xfer(WAKE_CMD, 6'd0);
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(posedge clk) #1;
    chk("woken", 8'(ready), 8'h01);
    xfer(SLEEP_CMD, 6'd0);
    for (i = 0; i < 400 && in_sleep !== 1'b1; i++) @(posedge clk) #1;
  endtask
  task automatic t_supply_loss();
    supply_ok = 1'b0;
    repeat (8) @(posedge clk) #1;
    chk("ready", 8'(ready), 8'h00);
    chk("in_sleep", 8'(in_sleep), 8'h00);
    chk("so_oe", 8'(spi_if.so_oe), 8'h00);
    chk("cs_n", 8'(spi_if.cs_n), 8'h01);
    t_power_up();
  endtask
  // ==================================================
  // Run control
  task automatic test_done();
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk) #1;
    t_power_up();
    t_delivered();
    t_unlock();
    t_commands();
    t_sleep();
    t_supply_loss();
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule // tb_serial_flash_power_sequencing
